// ### src/ltpg_pkg.sv
// package: constants and carrier types for the line test pattern generator
package ltpg_pkg;

    localparam int unsigned LTPG_PIX_W     = 12;
    localparam int unsigned LTPG_COL_W     = 16;
    localparam int unsigned LTPG_CNT_W     = 12;
    localparam int unsigned LTPG_SEL_W     = 3;
    localparam logic [LTPG_CNT_W-1:0] LTPG_CNT_RST = 12'h000;
    localparam logic [LTPG_COL_W-1:0] LTPG_COL_RST = 16'h0000;
    localparam logic [11:0] LTPG_MASK8  = 12'h0FF;
    localparam logic [11:0] LTPG_MASK12 = 12'hFFF;

    typedef enum logic [2:0] {
        LTPG_SEL_OFF   = 3'h0,
        LTPG_SEL_FIX8  = 3'h1,
        LTPG_SEL_MOV8  = 3'h2,
        LTPG_SEL_MOV12 = 3'h3,
        LTPG_SEL_FEAT8 = 3'h4,
        LTPG_SEL_FEAT12 = 3'h5
    } ltpg_sel_e;

    // one pixel beat of a line stream
    typedef struct packed {
        logic                  valid;
        logic                  sol;
        logic                  eol;
        logic [LTPG_PIX_W-1:0] data;
    } ltpg_pix_s;

endpackage

// ### src/ltpg_top.sv
// module: synthetic gray gradient line generator replacing sensor data
`timescale 1ns/100ps
// Summary of operation
// - selector picks one of five synthetic patterns, numbered one to five.
// - selector off passes sensor line data, no pattern generated.
// - pattern one gray equals column modulo 256, same every line.
// - line counter steps by exactly one on each new line start.
// - pattern two gray equals column plus counter modulo 256.
// - moving patterns shift one pixel right to left each line.
// - pattern three gray equals column plus counter modulo 4096.
// - pattern four is pattern two routed through digital processing.
// - pattern five is pattern three routed through digital processing.
// - patterns one to three bypass the digital processing chain.
// - active pattern replaces sensor pixel values, keeping the sensor pixel timing.
// - analog gain, black level, exposure do not affect pattern values.
module ltpg_top
    import ltpg_pkg::*;
(
    // clock and reset
    input  wire logic              clock,
    input  wire logic              resetn,
    input  wire logic              clk_en,
    // control
    input  wire ltpg_pkg::ltpg_sel_e test_sel,
    input  wire logic              line_start,
    // sensor stream (after analog front end)
    input  wire ltpg_pkg::ltpg_pix_s sensor_in,
    // digital processing chain loop
    output ltpg_pkg::ltpg_pix_s    proc_in,
    input  wire ltpg_pkg::ltpg_pix_s proc_out,
    // host output
    output ltpg_pkg::ltpg_pix_s    host_out,
    output logic                   pattern_active
);
    import ltpg_pkg::*;

    logic [LTPG_CNT_W-1:0] line_cnt_reg;
    logic [LTPG_COL_W-1:0] col_reg;
    logic                  bypass;
    logic                  active;
    logic                  feature;
    logic [LTPG_PIX_W-1:0] gray;
    ltpg_pix_s             gen_pix;

    function automatic logic [LTPG_PIX_W-1:0] grad(
        input logic [LTPG_COL_W-1:0] col,
        input logic [LTPG_CNT_W-1:0] cnt,
        input logic [11:0]           mask
    );
        logic [LTPG_PIX_W-1:0] sum;
        sum  = LTPG_PIX_W'(col) + cnt;
        grad = sum & mask;
    endfunction

    // true for the five pattern codes; 6 and 7 fall back to sensor data
    function automatic logic sel_is_pattern(
        input ltpg_sel_e sel
    );
        logic hit;
        hit = 1'b0;
        case (sel)
            LTPG_SEL_FIX8,
            LTPG_SEL_MOV8,
            LTPG_SEL_MOV12,
            LTPG_SEL_FEAT8,
            LTPG_SEL_FEAT12:
            begin
                hit = 1'b1;
            end
            default:
            begin
                hit = 1'b0;
            end
        endcase
        sel_is_pattern = hit;
    endfunction

    // of the pattern codes, only the feature-test codes are routed through the processing chain
    function automatic logic sel_is_feature(
        input ltpg_sel_e sel
    );
        logic hit;
        hit = 1'b0;
        case (sel)
            LTPG_SEL_FEAT8,
            LTPG_SEL_FEAT12:
            begin
                hit = 1'b1;
            end
            default:
            begin
                hit = 1'b0;
            end
        endcase
        sel_is_feature = hit;
    endfunction

    // 8-bit patterns keep the low byte, 12-bit patterns the full word
    function automatic logic [LTPG_PIX_W-1:0] pat_mask(
        input ltpg_sel_e sel
    );
        logic [LTPG_PIX_W-1:0] m;
        m = LTPG_MASK12;
        case (sel)
            LTPG_SEL_FIX8,
            LTPG_SEL_MOV8,
            LTPG_SEL_FEAT8:
            begin
                m = LTPG_MASK8;
            end
            default:
            begin
                m = LTPG_MASK12;
            end
        endcase
        pat_mask = m;
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // mode decode
    always_comb
    begin
        active  = sel_is_pattern(test_sel);
        feature = sel_is_feature(test_sel);
        bypass  = active && !feature;
        gray    = '0;
        case (test_sel)
            LTPG_SEL_FIX8:
            begin
                // counter held at zero: a stationary ramp
                gray = grad(col_reg, LTPG_CNT_RST, pat_mask(test_sel));
            end
            LTPG_SEL_MOV8,
            LTPG_SEL_FEAT8,
            LTPG_SEL_MOV12,
            LTPG_SEL_FEAT12:
            begin
                gray = grad(col_reg, line_cnt_reg, pat_mask(test_sel));
            end
            default:
            begin
                gray = '0;
            end
        endcase
        // pixel timing borrowed from the sensor stream, values never from it
        gen_pix.valid = sensor_in.valid;
        gen_pix.sol   = sensor_in.sol;
        gen_pix.eol   = sensor_in.eol;
        gen_pix.data  = gray;
    end

    ////////////////////////////////////////////////////////////////////////////
    // line counter: adding it to the column shifts the ramp left each line
    always_ff @(posedge clock or negedge resetn)
    begin
        if (!resetn)
            line_cnt_reg <= LTPG_CNT_RST;
        else if (clk_en && line_start)
            line_cnt_reg <= line_cnt_reg + 1'b1;
    end

    // column index; line_start or a valid eol beat clears it, so it restarts each line
    always_ff @(posedge clock or negedge resetn)
    begin
        if (!resetn)
            col_reg <= LTPG_COL_RST;
        else if (clk_en)
        begin
            if (line_start)
                col_reg <= LTPG_COL_RST;
            else if (sensor_in.valid)
                col_reg <= sensor_in.eol ? LTPG_COL_RST : col_reg + 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // routing: feature patterns and sensor data go through processing
    // status flag follows the selector one cycle later, like the data paths
    always_ff @(posedge clock or negedge resetn)
    begin
        if (!resetn)
        begin
            pattern_active <= 1'b0;
        end
        else if (clk_en)
        begin
            pattern_active <= active;
        end
    end

    // chain input: the generated line replaces sensor data only for feature codes
    always_ff @(posedge clock or negedge resetn)
    begin
        if (!resetn)
        begin
            proc_in <= '0;
        end
        else if (clk_en)
        begin
            if (feature)
            begin
                proc_in <= gen_pix;
            end
            else
            begin
                proc_in <= sensor_in;
            end
        end
    end

    // host output: bypass codes skip the chain, so digital gain cannot touch them
    always_ff @(posedge clock or negedge resetn)
    begin
        if (!resetn)
        begin
            host_out <= '0;
        end
        else if (clk_en)
        begin
            if (bypass)
            begin
                host_out <= gen_pix;
            end
            else
            begin
                host_out <= proc_out;
            end
        end
    end

endmodule // ltpg_top

// ### testbench/ltpg_asserts.sv
// checker: port assertions for the pattern generator
`timescale 1ns/100ps
module ltpg_asserts
    import ltpg_pkg::*;
(
    input wire logic      clock, resetn, clk_en, line_start, pattern_active,
    input wire ltpg_sel_e test_sel,
    input wire ltpg_pix_s sensor_in, proc_in, proc_out, host_out
);
    default clocking @(posedge clock); endclocking
    default disable iff (!resetn);
    sequence s_ramp(s);
        clk_en && test_sel == s && line_start && !sensor_in.valid
        ##1 clk_en && test_sel == s && !sensor_in.valid && !line_start
        ##1 clk_en && test_sel == s && sensor_in.valid && !line_start;
    endsequence
    // idle cycle between beats, as the bench spaces them
    sequence s_pair(s);
        clk_en && test_sel == s && sensor_in.valid && !sensor_in.eol && !line_start
        ##1 clk_en && test_sel == s && !sensor_in.valid && !line_start
        ##1 clk_en && test_sel == s && sensor_in.valid && !line_start;
    endsequence
    a_active_flag: assert property (clk_en |=> pattern_active == $past(test_sel inside {[1:5]}))
        else $error("pattern flag wrong");
    a_off_sensor: assert property (clk_en && test_sel == LTPG_SEL_OFF |=> proc_in == $past(sensor_in))
        else $error("sensor not passed");
    a_off_host: assert property (clk_en && test_sel == LTPG_SEL_OFF |=> host_out == $past(proc_out))
        else $error("host path wrong");
    a_feat_host: assert property (clk_en && test_sel inside {4, 5} |=> host_out == $past(proc_out))
        else $error("chain result lost");
    a_bypass_timing: assert property (clk_en && test_sel inside {[1:3]} |=> host_out.valid == $past(sensor_in.valid))
        else $error("bypass timing wrong");
    a_byte_width: assert property (clk_en && test_sel inside {1, 2} |=> host_out.data[11:8] == 4'h0)
        else $error("8 bit pattern too wide");
    a_ramp_origin: assert property (s_ramp(LTPG_SEL_FIX8) |=> host_out.data == 12'h000)
        else $error("ramp not at zero");
    a_step_by_one: assert property (s_pair(LTPG_SEL_MOV12) |=> host_out.data == $past(host_out.data, 2) + 12'h001)
        else $error("gradient step wrong");
endmodule // ltpg_asserts
bind ltpg_top ltpg_asserts i_chk (.*);

// ### testbench/ltpg_proc_model.sv
// partner: processing chain stand-in with a gain of two
`timescale 1ns/100ps
module ltpg_proc_model
    import ltpg_pkg::*;
(
    input  wire logic      clock,
    input  wire logic      resetn,
    input  wire ltpg_pix_s proc_in,
    output ltpg_pix_s      proc_out
);
    // overflow wraps: enough to tell routed data from bypassed data
    always_ff @(posedge clock or negedge resetn)
        if (!resetn) proc_out <= '0;
        else proc_out <= '{proc_in.valid, proc_in.sol, proc_in.eol, proc_in.data << 1};
endmodule // ltpg_proc_model

// ### testbench/line_scan_test_pattern_generator_tb.sv
// bench: lines through every pattern, compared with a model
`timescale 1ns/100ps
module line_scan_test_pattern_generator_tb;
    import ltpg_pkg::*;
    logic clock = 0, resetn = 0, line_start = 0, clk_en = 1, pattern_active;
    ltpg_sel_e test_sel = LTPG_SEL_OFF;
    ltpg_pix_s sensor_in = '0, proc_in, proc_out, host_out;
    int miscompares = 0, compares = 0, seed = 2, cnt = 0, col = 0;
    ltpg_top i_dut (.clock(clock), .resetn(resetn), .clk_en(clk_en), .test_sel(test_sel),
        .line_start(line_start), .sensor_in(sensor_in), .proc_in(proc_in), .proc_out(proc_out),
        .host_out(host_out), .pattern_active(pattern_active));
    ltpg_proc_model i_proc (.clock(clock), .resetn(resetn), .proc_in(proc_in), .proc_out(proc_out));
    initial forever #12.5 clock = ~clock;
    task chk(input logic [11:0] got, input logic [11:0] exp);
        compares++;
        if (got !== exp)
        begin
            miscompares++;
            $display("mismatch %0t: got %h exp %h", $time, got, exp);
        end
    endtask
    // one beat then an idle cycle; a line start carries no pixel
    task beat(input ltpg_sel_e s, input logic ls, input logic e);
        logic [11:0] d, x;
        logic fr;
        ltpg_pix_s hold;
        d = $random(seed);
        fr = ($random(seed) & 7) == 0;
        @(posedge clock);
        test_sel <= s;
        line_start <= ls;
        sensor_in <= '{~ls, 1'b0, e, d};
        clk_en <= !fr;
        cnt = ls ? cnt + 1 : cnt;
        col = ls ? 0 : col;
        x = (col + (s == LTPG_SEL_FIX8 ? 0 : cnt)) % (s inside {1, 2, 4} ? 256 : 4096);
        col = (ls || e) ? 0 : col + 1;
        // a frozen edge must neither take the beat nor move host_out
        if (fr)
        begin
            #1 hold = host_out;
            @(posedge clock);
            clk_en <= 1;
            #1 chk(12'(host_out == hold), 12'h001);
        end
        @(posedge clock);
        line_start <= 0;
        sensor_in.valid <= 0;
        #1;
        chk(12'(pattern_active), 12'(s inside {[1:5]}));
        if (!ls) chk(s inside {[1:3]} ? host_out.data : proc_in.data, s inside {[1:5]} ? x : d);
    endtask
    task stop_test;
        $display("compares %0d miscompares %0d", compares, miscompares);
        if (miscompares == 0 && compares > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    initial
    begin
        repeat (3) @(posedge clock);
        resetn <= 1;
        for (int s = 0; s < 8; s++)
        begin
            for (int l = 0; l < 3; l++)
            begin
                beat(ltpg_sel_e'(s), 1, 0);
                for (int p = 0; p < 5; p++) beat(ltpg_sel_e'(s), 0, p == 4);
            end
            $display("test of selector %0d done", s);
        end
        @(posedge clock);
        resetn <= 0;
        cnt = 0;
        col = 0;
        repeat (2) @(posedge clock);
        #1 chk(12'(host_out != '0 || pattern_active), 12'h000);
        @(posedge clock);
        resetn <= 1;
        $display("test of mid-run reset done");
        repeat (4097) beat(LTPG_SEL_MOV12, 1, 0);
        for (int p = 0; p < 3; p++) beat(LTPG_SEL_MOV12, 0, p == 2);
        $display("test of counter wrap done");
        stop_test;
    end
    initial
    begin
        #400us;
        miscompares++;
        stop_test;
    end
endmodule // line_scan_test_pattern_generator_tb
